// *** verilog/udc_core.sv ***
// udc_core: general control of a usb device controller behind apb
// assumes bus events arrive from a line monitor already in pclk domain
// except vbus and data-line levels, which are synchronised here
//
// Decided for this implementation: register access over APB and the address map.

module udc_core #(
  parameter int n_ep = udc_pkg::n_ep
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line monitor events, pclk domain, one-cycle pulses
  input  wire logic        bus_suspend,
  input  wire logic        bus_end_reset,
  input  wire logic [n_ep*8-1:0] ep_events,
  // asynchronous levels from pads
  input  wire logic        vbus_pin,
  input  wire logic        dline_pin,
  // pad, system and interrupt outputs
  output udc_pkg::udc_pad_s pad,
  output logic             ctrl_enabled,
  output logic             cpu_reset_req,
  output logic             cpu_wake,
  output logic             irq_general,
  output logic             irq_endpoint,
  output logic [9:0]       ep_buf_addr
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] vbus_sync;
  logic [1:0] dl_sync;
  logic       vbus_q;
  logic       dl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_sync <= 2'h0;
      dl_sync   <= 2'h0;
      vbus_q    <= 1'b0;
      dl_q      <= 1'b0;
    end else begin
      vbus_sync <= {vbus_sync[0], vbus_pin};
      dl_sync   <= {dl_sync[0], dline_pin};
      vbus_q    <= vbus_sync[1];
      dl_q      <= dl_sync[1];
    end
  end
  logic vbus_edge;
  logic dl_edge;
  assign vbus_edge = vbus_sync[1] ^ vbus_q;
  assign dl_edge   = dl_sync[1] ^ dl_q;

  // ----------------------------------------------------------------
  // apb decode: zero wait states, unmapped reads zero with error
  // ----------------------------------------------------------------
  logic wr;
  logic rd;
  logic mapped;
  assign wr     = psel && penable && pwrite;
  assign rd     = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= udc_pkg::clock_status_reg_off)
                  && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] gen_ctrl;
  logic [7:0] dev_ctrl;
  logic [7:0] dev_ien;
  logic [7:0] dev_flags;
  logic       vbus_flag;
  logic [2:0] ep_sel;
  logic       clk_src_ext;
  udc_pkg::udc_ep_cfg_s ep_cfg   [n_ep];
  logic       [n_ep-1:0] cfg_ok;
  logic       [7:0]      ep_flag [n_ep];
  logic       [7:0]      ep_ien  [n_ep];
  logic       [9:0]      ep_base [n_ep];
  udc_pkg::udc_state_e   state;

  logic macro_enable;
  logic clock_freeze;
  logic low_speed_select;
  logic detach;
  assign macro_enable     = gen_ctrl[udc_pkg::gc_macro_enable_bit];
  assign clock_freeze     = gen_ctrl[udc_pkg::gc_clock_freeze_bit];
  assign low_speed_select = dev_ctrl[udc_pkg::dc_low_speed_bit];
  assign detach           = dev_ctrl[udc_pkg::dc_detach_bit];

  // soft reset: macro off resets everything but the general regs and ep_sel
  logic soft_rst;
  logic usb_cpu_rst;
  assign soft_rst    = !macro_enable;
  assign usb_cpu_rst = bus_end_reset && dev_ctrl[udc_pkg::dc_cpu_reset_bit];

  function automatic logic hit(input logic [7:0] off);
    hit = (paddr == off);
  endfunction

  // size of a reserved endpoint in bytes, banks included
  function automatic logic [9:0] ep_bytes(input udc_pkg::udc_ep_cfg_s c);
    logic [9:0] one;
    one = 10'(10'h008 << c.size_code);
    ep_bytes = c.two_banks ? 10'(one << 1) : one;
  endfunction

  // ----------------------------------------------------------------
  // general registers: writable while frozen, only hard reset clears
  // ----------------------------------------------------------------
  logic [7:0] next_gen_ctrl;
  logic       next_vbus_flag;
  logic       next_clk_src_ext;
  always_comb begin
    next_gen_ctrl    = gen_ctrl;
    next_vbus_flag   = vbus_flag;
    next_clk_src_ext = clk_src_ext;
    if (wr && hit(udc_pkg::general_control_reg_off))
      next_gen_ctrl = pwdata[7:0] & 8'ha1;
    if (wr && hit(udc_pkg::general_interrupt_reg_off) && !pwdata[0])
      next_vbus_flag = 1'b0;
    if (wr && hit(udc_pkg::clock_status_reg_off))
      next_clk_src_ext = pwdata[udc_pkg::cs_src_external_bit];
    if (vbus_edge)
      next_vbus_flag = 1'b1;  // set beats clear, works frozen
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_ctrl    <= udc_pkg::gc_reset;
      vbus_flag   <= 1'b0;
      clk_src_ext <= 1'b0;
    end else begin
      gen_ctrl    <= next_gen_ctrl;
      vbus_flag   <= next_vbus_flag;
      clk_src_ext <= next_clk_src_ext;
    end
  end

  // ----------------------------------------------------------------
  // device control, flags and controller state
  // ----------------------------------------------------------------
  logic [7:0] next_dev_ctrl;
  logic [7:0] next_dev_ien;
  logic [7:0] next_dev_flags;
  udc_pkg::udc_state_e next_state;
  always_comb begin
    next_dev_ctrl  = dev_ctrl;
    next_dev_ien   = dev_ien;
    next_dev_flags = dev_flags;
    next_state     = state;
    if (wr && hit(udc_pkg::device_control_reg_off))
      next_dev_ctrl = pwdata[7:0] & 8'h07;
    if (wr && hit(udc_pkg::device_interrupt_enable_reg_off))
      next_dev_ien = pwdata[7:0] & 8'h19;
    if (wr && hit(udc_pkg::device_interrupt_reg_off))
      next_dev_flags = dev_flags & pwdata[7:0];  // write zero clears
    // clock-dependent events are dropped while frozen
    if (!clock_freeze && bus_suspend)
      next_dev_flags[udc_pkg::di_suspend_bit] = 1'b1;
    if (!clock_freeze && bus_end_reset)
      next_dev_flags[udc_pkg::di_end_reset_bit] = 1'b1;
    if (dl_edge)  // async wake source
      next_dev_flags[udc_pkg::di_wakeup_bit] = 1'b1;
    unique case (state)
      udc_pkg::udc_reset_st:
        if (macro_enable) next_state = udc_pkg::udc_idle_st;
      udc_pkg::udc_idle_st:
        if (dl_edge) next_state = udc_pkg::udc_active_st;
      udc_pkg::udc_active_st:
        if (bus_suspend && !clock_freeze)
          next_state = udc_pkg::udc_idle_st;
      default: next_state = udc_pkg::udc_reset_st;
    endcase
    if (soft_rst) begin  // acts like hardware reset
      next_dev_ctrl  = udc_pkg::dc_reset;
      next_dev_ien   = 8'h00;
      next_dev_flags = 8'h00;
      next_state     = udc_pkg::udc_reset_st;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_ctrl  <= udc_pkg::dc_reset;
      dev_ien   <= 8'h00;
      dev_flags <= 8'h00;
      state     <= udc_pkg::udc_reset_st;
    end else begin
      dev_ctrl  <= next_dev_ctrl;
      dev_ien   <= next_dev_ien;
      dev_flags <= next_dev_flags;
      state     <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // endpoint configuration, flags and ordered allocation
  // ----------------------------------------------------------------
  udc_pkg::udc_ep_cfg_s next_ep_cfg [n_ep];
  logic [n_ep-1:0] next_cfg_ok;
  logic [7:0]      next_ep_flag [n_ep];
  logic [7:0]      next_ep_ien  [n_ep];
  logic [9:0]      next_ep_base [n_ep];
  logic            sel_wr;
  assign sel_wr = wr && hit(udc_pkg::ep_config_reg_off);
  always_comb begin
    for (int i = 0; i < n_ep; i++) begin
      next_ep_cfg[i]  = ep_cfg[i];
      next_cfg_ok[i]  = cfg_ok[i];
      next_ep_flag[i] = ep_flag[i];
      next_ep_ien[i]  = ep_ien[i];
      next_ep_base[i] = ep_base[i];
      if (ep_sel == 3'(i)) begin
        if (sel_wr) begin
          // every write loads enable, reserve, size and banks together
          next_ep_cfg[i].enable    = pwdata[udc_pkg::ec_enable_bit];
          next_ep_cfg[i].reserve   = pwdata[udc_pkg::ec_reserve_bit];
          next_ep_cfg[i].two_banks = pwdata[udc_pkg::ec_bank_bit];
          next_ep_cfg[i].size_code = pwdata[udc_pkg::ec_size_lsb +: 3];
          // accepted even on overlap; refused without reserve or above ram size.
          // sized wide so the largest code cannot wrap to zero
          next_cfg_ok[i] = pwdata[udc_pkg::ec_reserve_bit] &&
            ((12'(12'h008 << pwdata[udc_pkg::ec_size_lsb +: 3])
              << pwdata[udc_pkg::ec_bank_bit]) <=
             12'(udc_pkg::dpram_bytes));
        end
        if (wr && hit(udc_pkg::ep_int_flag_reg_off))
          next_ep_flag[i] = ep_flag[i] & pwdata[7:0];
        if (wr && hit(udc_pkg::ep_int_enable_reg_off))
          next_ep_ien[i] = pwdata[7:0];
      end
      if (!clock_freeze)
        next_ep_flag[i] = next_ep_flag[i] | ep_events[i*8 +: 8];
      // endpoint 0 sits at the bottom and never moves
      if (i == 0)
        next_ep_base[i] = 10'h000;
      // only the endpoint right above a changed one restacks; the
      // enable bit alone never moves memory, nor does a same re-reserve
      else if (ep_cfg[i-1][4:0] != next_ep_cfg[i-1][4:0])
        next_ep_base[i] = next_ep_cfg[i-1].reserve ?
          10'(next_ep_base[i-1] + ep_bytes(next_ep_cfg[i-1])) :
          next_ep_base[i-1];
      if (soft_rst || usb_cpu_rst) begin
        next_ep_cfg[i]  = '0;
        next_cfg_ok[i]  = 1'b0;
        next_ep_flag[i] = 8'h00;
        next_ep_ien[i]  = 8'h00;
        next_ep_base[i] = 10'h000;
      end
    end
  end
  // a changed endpoint moves only its upper neighbour; endpoints two
  // or more above keep their base, so overlaps are possible by design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < n_ep; i++) begin
        ep_cfg[i]  <= '0;
        ep_flag[i] <= 8'h00;
        ep_ien[i]  <= 8'h00;
        ep_base[i] <= 10'h000;
      end
      cfg_ok <= '0;
      ep_sel <= 3'h0;
    end else begin
      for (int i = 0; i < n_ep; i++) begin
        ep_cfg[i]  <= next_ep_cfg[i];
        ep_flag[i] <= next_ep_flag[i];
        ep_ien[i]  <= next_ep_ien[i];
        ep_base[i] <= next_ep_base[i];
      end
      cfg_ok <= next_cfg_ok;
      if (wr && hit(udc_pkg::ep_select_reg_off) && int'(pwdata[2:0]) < n_ep)
        ep_sel <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupts, pads and read mux
  // ----------------------------------------------------------------
  logic [n_ep-1:0] ep_summary;
  always_comb begin
    for (int i = 0; i < n_ep; i++)
      ep_summary[i] = |(ep_flag[i] & ep_ien[i]);
  end
  logic fs_allowed;
  assign fs_allowed = clk_src_ext;  // rc source: low speed only
  logic attach;
  assign attach = !detach && vbus_sync[1] && macro_enable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_general   <= 1'b0;
      irq_endpoint  <= 1'b0;
      cpu_wake      <= 1'b0;
      cpu_reset_req <= 1'b0;
      ctrl_enabled  <= 1'b0;
      pad           <= '{pad_idle: 1'b1, pullup_dp: 1'b0, pullup_dm: 1'b0};
    end else begin
      // levels held while any enabled flag stays set
      irq_general  <= |(dev_flags & dev_ien) ||
                      (vbus_flag && gen_ctrl[udc_pkg::gc_vbus_int_en_bit]);
      irq_endpoint <= |ep_summary;
      cpu_wake     <= |(dev_flags & dev_ien) || |ep_summary ||
                      vbus_flag || dev_flags[udc_pkg::di_wakeup_bit];
      cpu_reset_req <= usb_cpu_rst;  // controller stays enabled
      ctrl_enabled  <= macro_enable;
      // suspend or detach idles pad; wakeup returns it
      pad.pad_idle  <= state != udc_pkg::udc_active_st || detach;
      pad.pullup_dm <= attach && low_speed_select;
      pad.pullup_dp <= attach && !low_speed_select && fs_allowed;
    end
  end
  assign ep_buf_addr = ep_base[ep_sel];

  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        udc_pkg::general_control_reg_off:   prdata[7:0] = gen_ctrl;
        udc_pkg::general_status_reg_off:
          prdata[1:0] = {1'b1, vbus_sync[1]};
        udc_pkg::general_interrupt_reg_off: prdata[0]   = vbus_flag;
        udc_pkg::device_control_reg_off:    prdata[7:0] = dev_ctrl;
        udc_pkg::device_interrupt_reg_off:  prdata[7:0] = dev_flags;
        udc_pkg::device_interrupt_enable_reg_off: prdata[7:0] = dev_ien;
        udc_pkg::ep_select_reg_off:         prdata[2:0] = ep_sel;
        udc_pkg::ep_config_reg_off:
          prdata[8:0] = {cfg_ok[ep_sel], 1'b0, ep_cfg[ep_sel].size_code,
                         1'b0, ep_cfg[ep_sel].two_banks,
                         ep_cfg[ep_sel].reserve, ep_cfg[ep_sel].enable};
        udc_pkg::ep_int_flag_reg_off:       prdata[7:0] = ep_flag[ep_sel];
        udc_pkg::ep_int_enable_reg_off:     prdata[7:0] = ep_ien[ep_sel];
        udc_pkg::endpoint_interrupt_summary_off:
          prdata[n_ep-1:0] = ep_summary;
        udc_pkg::ep_base_reg_off:           prdata[9:0] = ep_base[ep_sel];
        udc_pkg::clock_status_reg_off:
          prdata[1:0] = {fs_allowed, clk_src_ext};
        default:                            prdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence vbus_toggle_s;
    vbus_edge;
  endsequence
  chk_vbus_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    vbus_toggle_s |=> vbus_flag)
    else $error("vbus edge did not set flag");
  chk_macro_off_rst: assert property (@(posedge pclk) disable iff (!presetn)
    !macro_enable |=> state == udc_pkg::udc_reset_st && dev_flags == 8'h00)
    else $error("macro off did not reset controller");
  chk_freeze_no_susp: assert property (@(posedge pclk) disable iff (!presetn)
    clock_freeze && $stable(dev_ctrl) && !wr |=> !$rose(dev_flags[0]))
    else $error("suspend flagged while frozen");
  chk_pullup_select: assert property (@(posedge pclk) disable iff (!presetn)
    attach && low_speed_select |=> pad.pullup_dm && !pad.pullup_dp)
    else $error("low speed pull-up wrong");
  chk_no_pullup: assert property (@(posedge pclk) disable iff (!presetn)
    detach |=> !pad.pullup_dm && !pad.pullup_dp && pad.pad_idle)
    else $error("pull-up while detached");
  chk_ep0_base: assert property (@(posedge pclk) disable iff (!presetn)
    ep_base[0] == 10'h000)
    else $error("endpoint zero moved");
  chk_ep_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|ep_summary) [*2] |-> irq_endpoint)
    else $error("endpoint irq not held");
  chk_cpu_rst_en: assert property (@(posedge pclk) disable iff (!presetn)
    usb_cpu_rst && macro_enable |=> cpu_reset_req && ctrl_enabled)
    else $error("cpu reset disabled controller");
endmodule // udc_core

// *** include/udc_pkg.sv ***
// udc_pkg: shared constants and types for the usb device general core
// assumes an apb slave with 32-bit data on a 125 MHz pclk
package udc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] general_control_reg_off          = 8'h00;
  localparam logic [7:0] general_status_reg_off           = 8'h04;
  localparam logic [7:0] general_interrupt_reg_off        = 8'h08;
  localparam logic [7:0] device_control_reg_off           = 8'h0c;
  localparam logic [7:0] device_interrupt_reg_off         = 8'h10;
  localparam logic [7:0] device_interrupt_enable_reg_off  = 8'h14;
  localparam logic [7:0] ep_select_reg_off                = 8'h18;
  localparam logic [7:0] ep_config_reg_off                = 8'h1c;
  localparam logic [7:0] ep_int_flag_reg_off              = 8'h20;
  localparam logic [7:0] ep_int_enable_reg_off            = 8'h24;
  localparam logic [7:0] endpoint_interrupt_summary_off   = 8'h28;
  localparam logic [7:0] ep_base_reg_off                  = 8'h2c;
  localparam logic [7:0] clock_status_reg_off             = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // general control
  localparam int gc_macro_enable_bit   = 7;
  localparam int gc_clock_freeze_bit   = 5;
  localparam int gc_vbus_int_en_bit    = 0;
  // general status
  localparam int gs_id_bit             = 1;
  localparam int gs_vbus_bit           = 0;
  // device control
  localparam int dc_low_speed_bit      = 2;
  localparam int dc_cpu_reset_bit      = 1;
  localparam int dc_detach_bit         = 0;
  // device interrupt flags / enables
  localparam int di_wakeup_bit         = 4;
  localparam int di_end_reset_bit      = 3;
  localparam int di_suspend_bit        = 0;
  // endpoint configuration
  localparam int ec_enable_bit         = 0;
  localparam int ec_reserve_bit        = 1;
  localparam int ec_bank_bit           = 2;
  localparam int ec_size_lsb           = 4;
  localparam int ec_cfg_ok_bit         = 8;
  // clock status (source select written, full-speed legality read)
  localparam int cs_src_external_bit   = 0;
  localparam int cs_fs_allowed_bit     = 1;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0]  gc_reset    = 8'h20;  // freeze set, macro off
  localparam logic [7:0]  dc_reset    = 8'h01;  // detached
  localparam int          n_ep        = 7;
  localparam int          dpram_bytes = 832;
  localparam int          ep0_max     = 64;
  localparam int          ep1_max     = 256;
  localparam int          epn_max     = 64;
  localparam int          ref_khz     = 48000;
  localparam int          fs_bit_khz  = 12000;
  localparam int          ls_bit_khz  = 1500;
  localparam int          ref_tol_ppm = 2500;

  // controller states, one-hot
  typedef enum logic [2:0] {
    udc_reset_st  = 3'b001,
    udc_idle_st   = 3'b010,
    udc_active_st = 3'b100
  } udc_state_e;

  // pad-facing signals
  typedef struct packed {
    logic pad_idle;
    logic pullup_dp;
    logic pullup_dm;
  } udc_pad_s;

  // per-endpoint configuration
  typedef struct packed {
    logic       enable;
    logic       reserve;
    logic       two_banks;
    logic [2:0] size_code;  // 8 << code bytes
  } udc_ep_cfg_s;
endpackage

// *** verif/udc_host_model.sv ***
// udc_host_model: far side of the usb lines as seen by the core
// assumes the bench commands it on pclk; 1 suspend, 2 resume, 3 end reset
module udc_host_model (
  // bench control
  input  wire logic       pclk,
  input  wire logic       plug,
  input  wire logic [1:0] cmd,
  // line levels and monitor pulses toward the core
  output logic            vbus_pin,
  output logic            dline_pin,
  output logic            bus_suspend,
  output logic            bus_end_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // line behaviour
  // ------------------------------------------------------------
  // data line starts quiet so the core sees no stray edge
  logic dl_lvl = 1'b0;
  assign dline_pin = dl_lvl;
  // pulses last one cycle; resume flips the data line level
  always @(posedge pclk) begin
    vbus_pin      <= plug;
    bus_suspend   <= cmd == 2'h1;
    bus_end_reset <= cmd == 2'h3;
    if (cmd == 2'h2) begin
      dl_lvl <= ~dl_lvl;
    end
  end
endmodule // udc_host_model

// *** verif/udc_core_tb_top.sv ***
// udc_core_tb_top: self-checking bench for the general usb core
// assumes zero-wait apb slave and the host model on the line side
module udc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        plug, ctrl_enabled, cpu_reset_req, cpu_wake;
  logic        irq_general, irq_endpoint, vbus_pin, dline_pin;
  logic        bus_suspend, bus_end_reset;
  logic [1:0]  cmd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, ev, mv;
  logic [55:0] ep_events;
  logic [9:0]  ep_buf_addr;
  udc_pkg::udc_pad_s pad;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_total, n_tests, cyc, ep, k, n_rst;
  udc_core i_udc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_suspend(bus_suspend), .bus_end_reset(bus_end_reset),
    .ep_events(ep_events), .vbus_pin(vbus_pin), .dline_pin(dline_pin),
    .pad(pad), .ctrl_enabled(ctrl_enabled), .cpu_reset_req(cpu_reset_req),
    .cpu_wake(cpu_wake), .irq_general(irq_general),
    .irq_endpoint(irq_endpoint), .ep_buf_addr(ep_buf_addr));
  udc_host_model i_udc_host_model (.pclk(pclk), .plug(plug), .cmd(cmd),
    .vbus_pin(vbus_pin), .dline_pin(dline_pin),
    .bus_suspend(bus_suspend), .bus_end_reset(bus_end_reset));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #4 pclk = ~pclk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // two idle edges so registered outputs have settled for checks
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask
  task automatic host(input logic [1:0] c);
    cmd <= c;
    @(posedge pclk);
    cmd <= 2'h0;
    repeat (6) @(posedge pclk);
  endtask
  // read data is judged at the completing edge against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      // offsets above the map are refused, as are unaligned ones, which the bench never drives
      cmp({31'h0, pslverr},
          {31'h0, paddr > udc_pkg::clock_status_reg_off});
      if (!pwrite) begin
        ev = exp_q.pop_front();
        mv = msk_q.pop_front();
        cmp(prdata & mv, ev & mv);
      end
    end
  end
  // the cpu reset request is a one-cycle pulse: count it as it passes
  always @(posedge pclk) begin
    if (cpu_reset_req) n_rst++;
  end
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, plug} = '0;
    {paddr, pwdata, cmd, ep_events} = '0;
    void'($urandom(53168));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 32'h20, 32'hff);
    apb(0, 8'h0c, 32'h01, 32'hff);
    apb(0, 8'h04, 32'h02, 32'h03);
    apb(0, 8'h3c, 32'h00, 32'hffffffff);
    cmp({31'h0, pad.pad_idle}, 32'h1);
    cmp({31'h0, ctrl_enabled}, 32'h0);
    wr(8'h00, 32'h81);
    cmp({31'h0, ctrl_enabled}, 32'h1);
    wr(8'h30, 32'h01);
    plug <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(0, 8'h08, 32'h01, 32'h01);
    cmp({31'h0, irq_general}, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h00);
    cmp({29'h0, pad}, 32'h6);
    wr(8'h0c, 32'h04);
    cmp({29'h0, pad}, 32'h5);
    wr(8'h0c, 32'h05);
    cmp({29'h0, pad}, 32'h4);
    wr(8'h0c, 32'h00);
    wr(8'h14, 32'h11);
    host(2'h1);
    apb(0, 8'h10, 32'h01, 32'h01);
    cmp({31'h0, pad.pad_idle}, 32'h1);
    cmp({31'h0, irq_general}, 32'h1);
    cmp({31'h0, cpu_wake}, 32'h1);
    host(2'h2);
    apb(0, 8'h10, 32'h10, 32'h10);
    cmp({31'h0, pad.pad_idle}, 32'h0);
    // frozen clock: suspend ignored, line change still flagged
    wr(8'h00, 32'ha1);
    wr(8'h10, 32'h0);
    host(2'h1);
    host(2'h2);
    apb(0, 8'h10, 32'h10, 32'h11);
    apb(0, 8'h0c, 32'h00, 32'h07);
    wr(8'h00, 32'h81);
    ep = $urandom_range(6, 0);
    k = $urandom_range(7, 0);
    wr(8'h18, ep);
    wr(8'h24, 32'h1 << k);
    ep_events <= 56'h1 << (ep * 8 + k);
    @(posedge pclk);
    ep_events <= '0;
    repeat (3) @(posedge pclk);
    cmp({31'h0, irq_endpoint}, 32'h1);
    apb(0, 8'h28, 32'h1 << ep, 32'h7f);
    // firmware reserves in rising order: ep0 64, ep1 256, ep2 64 bytes
    wr(8'h18, 32'h0);
    wr(8'h1c, 32'h33);
    wr(8'h18, 32'h1);
    wr(8'h1c, 32'h53);
    apb(0, 8'h1c, 32'h153, 32'h1ff);
    wr(8'h18, 32'h2);
    wr(8'h1c, 32'h33);
    cmp({22'h0, ep_buf_addr}, 32'h140);
    wr(8'h18, 32'h3);
    apb(0, 8'h2c, 32'h180, 32'h3ff);
    // freeing ep1 pulls ep2 down while ep3 keeps its place
    wr(8'h18, 32'h1);
    wr(8'h1c, 32'h50);
    wr(8'h18, 32'h2);
    apb(0, 8'h2c, 32'h40, 32'h3ff);
    wr(8'h1c, 32'h32);
    wr(8'h1c, 32'h33);
    wr(8'h18, 32'h3);
    apb(0, 8'h2c, 32'h180, 32'h3ff);
    wr(8'h1c, 32'h73);
    apb(0, 8'h1c, 32'h073, 32'h1ff);
    wr(8'h0c, 32'h02);
    host(2'h3);
    cmp(n_rst, 32'h1);
    cmp({31'h0, ctrl_enabled}, 32'h1);
    wr(8'h00, 32'h01);
    apb(0, 8'h0c, 32'h01, 32'hff);
    cmp({31'h0, pad.pad_idle}, 32'h1);
    print_verdict();
  end
endmodule // udc_core_tb_top
